// ### core/port_mode_config_cfg.svh
`ifndef PORT_MODE_CONFIG_CFG_SVH
`define PORT_MODE_CONFIG_CFG_SVH
// Register offsets within the configuration I/O space
`define OFS_MODE_A 8'h02
`define OFS_MODE_B 8'h03
`define OFS_DIR_A 8'h04
`define OFS_DIR_B 8'h05
`define OFS_DIR_C 8'h12
`define OFS_DIR_D 8'h13
`define OFS_DRV_A 8'h06
`define OFS_DRV_B 8'h07
`define OFS_DRV_C 8'h14
`define OFS_DRV_D 8'h15
`define CFG_RESET 8'h00
// Implemented bits
`define DIR_D_MASK 8'h06
`define DRV_D_MASK 8'h06
// Drive-select field split on ports A and B
`define OD_FIELD_MASK 8'hf0
`define SLEW_FIELD_MASK 8'h0f
// Port C pins able to carry group-two macrocells
`define MC2_PORTC_MASK 8'h9c
`define PERIPH_BIT 7
`endif

// ### core/port_mode_config_pkg.sv
package port_mode_config_pkg;
   typedef logic [7:0] byte_type;
   typedef enum logic [1:0] {PORT_A, PORT_B, PORT_C, PORT_D} port_type;
   typedef enum logic [2:0]
   {
      SEL_MODE = 3'b001,
      SEL_DIR = 3'b010,
      SEL_DRV = 3'b100
   } regsel_type;
endpackage

// ### core/cfg_bus_if.sv
`timescale 1ns/1ns
interface cfg_bus_if;
   import port_mode_config_pkg::*;
   logic wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic hit;
   modport master (output wr, output addr, output wdata,
      input rdata, input hit);
   modport slave (input wr, input addr, input wdata,
      output rdata, output hit);
endinterface

// ### core/port_cfg_regs.sv
`timescale 1ns/1ns
`include "port_mode_config_cfg.svh"
module port_cfg_regs
   import port_mode_config_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic rst, // Sync reset
   cfg_bus_if.slave bus, // Register access
   output byte_type mode_a, // Mode select A
   output byte_type mode_b, // Mode select B
   output byte_type dir_a, // Direction A
   output byte_type dir_b, // Direction B
   output byte_type dir_c, // Direction C
   output byte_type dir_d, // Direction D
   output byte_type drv_a, // Drive A
   output byte_type drv_b, // Drive B
   output byte_type drv_c, // Drive C
   output byte_type drv_d // Drive D
);
   byte_type regs_q [10];
   byte_type regs_d [10];
   byte_type rd;
   logic hit;

   // ---------------------------------------------
   // Decode
   // ---------------------------------------------
   function automatic logic [3:0] idx(input logic [7:0] a);
      unique case (a)
         `OFS_MODE_A: idx = 4'h0;
         `OFS_MODE_B: idx = 4'h1;
         `OFS_DIR_A: idx = 4'h2;
         `OFS_DIR_B: idx = 4'h3;
         `OFS_DIR_C: idx = 4'h4;
         `OFS_DIR_D: idx = 4'h5;
         `OFS_DRV_A: idx = 4'h6;
         `OFS_DRV_B: idx = 4'h7;
         `OFS_DRV_C: idx = 4'h8;
         `OFS_DRV_D: idx = 4'h9;
         default: idx = 4'hf;
      endcase
   endfunction

   // Port D keeps only pins 2 and 1 [RULE11]
   function automatic byte_type imask(input logic [3:0] i);
      unique case (i)
         4'h5: imask = `DIR_D_MASK;
         4'h9: imask = `DRV_D_MASK;
         default: imask = 8'hff;
      endcase
   endfunction

   always_comb
   begin
      hit = (idx(bus.addr) != 4'hf);
      rd = 8'h00;
      for (int i = 0; i < 10; i++)
      begin
         regs_d[i] = regs_q[i];
      end
      if (hit)
      begin
         rd = regs_q[idx(bus.addr)]; // [RULE17]
      end
      if (bus.wr && hit)
      begin
         regs_d[idx(bus.addr)] = bus.wdata & imask(idx(bus.addr)); // [RULE18]
      end
   end

   always_ff @(posedge clk)
   begin
      for (int i = 0; i < 10; i++)
      begin
         if (rst)
         begin
            regs_q[i] <= `CFG_RESET; // [RULE6]
         end
         else
         begin
            regs_q[i] <= regs_d[i];
         end
      end
   end

   assign bus.rdata = rd;
   assign bus.hit = hit;
   assign mode_a = regs_q[0];
   assign mode_b = regs_q[1];
   assign dir_a = regs_q[2];
   assign dir_b = regs_q[3];
   assign dir_c = regs_q[4];
   assign dir_d = regs_q[5];
   assign drv_a = regs_q[6];
   assign drv_b = regs_q[7];
   assign drv_c = regs_q[8];
   assign drv_d = regs_q[9];

   property p_reset_clears;
      @(posedge clk) rst |=> (regs_q[0] == 8'h00 && regs_q[5] == 8'h00);
   endproperty
   a_reset_clears: assert property (p_reset_clears) // [RULE6]
      else $error("config register not cleared by reset");

   property p_portd_mask;
      @(posedge clk) disable iff (rst) (regs_q[5] & 8'hf9) == 8'h00;
   endproperty
   a_portd_mask: assert property (p_portd_mask) // [RULE11]
      else $error("unimplemented port D direction bit set");
endmodule // port_cfg_regs

// ### core/port_mode_config.sv
// Functional notes
// RULE1: Port A/B mode bit 0 gives processor I/O, 1 gives address out.
// RULE2: Only ports A and B have mode select; C and D are processor I/O.
// RULE3: Direction bit 1 makes pin an output, 0 an input.
// RULE4: Output enable is direction bit OR logic-array enable term.
// RULE5: Inactive enable term leaves direction to the direction bit alone.
// RULE6: All configuration registers reset to zero.
// RULE7: Bit n of each register controls pin n of its port only.
// RULE8: Drive bit 1 selects open drain, 0 push-pull, where supported.
// RULE9: Drive bit 1 selects fast slew, 0 slow, where supported.
// RULE10: Address out drives latched address bits 7..0 on pins 7..0.
// RULE11: Port D direction has only pins 2 and 1 implemented.
// RULE12: Processor uses plain read and write cycles at fixed offsets.
// RULE13: Group-two macrocells reach port C only on pins 2, 3, 4, 7.
// RULE14: Mode register bit 7 makes port A a bidirectional data buffer.
// RULE15: A/B drive bits 7..4 open drain, 3..0 slew; port C all open drain.
// RULE16: Processor I/O drives data out when pin output is enabled.
// RULE17: Reads return last written value, zero after reset.
// RULE18: Unimplemented bits read zero and ignore writes.
`timescale 1ns/1ns
`include "port_mode_config_cfg.svh"
module port_mode_config
   import port_mode_config_pkg::*;
(
   input wire logic CLK, // 10 MHz clock
   input wire logic RST, // Sync reset, high
   input wire logic BUS_WR, // Register write strobe
   input wire logic BUS_RD, // Register read strobe
   input wire logic [7:0] BUS_ADDR, // Offset in config space
   input wire logic [7:0] BUS_WDATA, // Write data
   output logic [7:0] BUS_RDATA, // Read data
   input wire logic [7:0] MEM_MAP_MODE, // Memory map mode register
   input wire logic PERIPH_SELECT_A, // Peripheral select term
   input wire logic PERIPH_SELECT_B, // Peripheral select term
   input wire logic [7:0] CPU_DATA_OUT, // Processor data to buffer
   input wire logic [7:0] LATCHED_ADDR, // Latched address low byte
   input wire logic [31:0] DATA_OUT, // Data out regs, port per byte
   input wire logic [31:0] PLA_OE, // Logic-array enable terms
   input wire logic [31:0] PLA_CLAIM, // Logic-array owns pin
   input wire logic [7:0] MACROCELL_GROUP_ONE, // To port A or B
   input wire logic [7:0] MACROCELL_GROUP_TWO, // To port B or C
   input wire logic [7:0] MC2_TO_C, // Set: port B pin takes group one instead of group two
   output logic [31:0] PIN_OUT, // Pin output levels
   output logic [31:0] PIN_OE, // Pin output enables
   output logic [31:0] PIN_OPEN_DRAIN, // Open-drain select
   output logic [31:0] PIN_FAST_SLEW, // Fast slew select
   output logic PERIPH_BUFFER_ENABLE // Port A data buffer on
);
   cfg_bus_if bus ();
   byte_type mode_a, mode_b, dir_a, dir_b, dir_c, dir_d;
   byte_type drv_a, drv_b, drv_c, drv_d;
   logic [31:0] dir_all, mode_all, drv_all;
   logic [31:0] out_d, oe_d, od_d, slew_d, out_q, oe_q, od_q, slew_q;
   logic [7:0] rdata_d, rdata_q;
   logic pio_d, pio_q;

   assign bus.wr = BUS_WR;
   assign bus.addr = BUS_ADDR;
   assign bus.wdata = BUS_WDATA;

   port_cfg_regs u_regs
   (
      .clk(CLK),
      .rst(RST),
      .bus(bus.slave),
      .mode_a(mode_a),
      .mode_b(mode_b),
      .dir_a(dir_a),
      .dir_b(dir_b),
      .dir_c(dir_c),
      .dir_d(dir_d),
      .drv_a(drv_a),
      .drv_b(drv_b),
      .drv_c(drv_c),
      .drv_d(drv_d)
   );

   // ---------------------------------------------
   // Per-pin configuration
   // ---------------------------------------------
   // C and D have no mode register, so their mode bits are zero
   assign mode_all = {8'h00, 8'h00, mode_b, mode_a}; // [RULE2]
   assign dir_all = {dir_d, dir_c, dir_b, dir_a};
   assign drv_all = {drv_d, drv_c, drv_b, drv_a};

   always_comb
   begin
      pio_d = MEM_MAP_MODE[`PERIPH_BIT] &
         (PERIPH_SELECT_A | PERIPH_SELECT_B); // [RULE14]
      for (int p = 0; p < 4; p++)
      begin
         for (int n = 0; n < 8; n++)
         begin
            // Pin n sees only bit n of its own port [RULE7]
            oe_d[p*8+n] = dir_all[p*8+n] | PLA_OE[p*8+n]; // [RULE3] [RULE4] [RULE5]
            if (mode_all[p*8+n])
            begin
               out_d[p*8+n] = LATCHED_ADDR[n]; // [RULE1] [RULE10]
            end
            else
            begin
               out_d[p*8+n] = DATA_OUT[p*8+n]; // [RULE16]
            end
         end
      end
      // Logic-array claims on ports A and B, and on port C pins 2, 3, 4, 7, override processor I/O
      for (int n = 0; n < 8; n++)
      begin
         if (PLA_CLAIM[n])
         begin
            out_d[n] = MACROCELL_GROUP_ONE[n];
         end
         if (PLA_CLAIM[8+n])
         begin
            out_d[8+n] = MC2_TO_C[n] ? MACROCELL_GROUP_ONE[n]
               : MACROCELL_GROUP_TWO[n];
         end
         // Other port C drivers have no macrocell path; claim is ignored
         if (PLA_CLAIM[16+n] && ((`MC2_PORTC_MASK >> n) & 8'h01) != 8'h00)
         begin
            out_d[16+n] = MACROCELL_GROUP_TWO[n]; // [RULE13]
         end
      end
      // Peripheral buffer takes over all of port A
      if (pio_d)
      begin
         out_d[7:0] = CPU_DATA_OUT;
         oe_d[7:0] = 8'hff;
      end
      else if (MEM_MAP_MODE[`PERIPH_BIT])
      begin
         oe_d[7:0] = 8'h00; // [RULE14]
      end
      // Drive field split per port
      od_d = {8'h00, drv_c, drv_b & `OD_FIELD_MASK,
         drv_a & `OD_FIELD_MASK}; // [RULE8] [RULE15]
      slew_d = {drv_d, 8'h00, drv_b & `SLEW_FIELD_MASK,
         drv_a & `SLEW_FIELD_MASK}; // [RULE9] [RULE15]
      rdata_d = (BUS_RD && bus.hit) ? bus.rdata : 8'h00;
   end

   // ---------------------------------------------
   // Output registers
   // ---------------------------------------------
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         out_q <= 32'h00000000;
         oe_q <= 32'h00000000;
         od_q <= 32'h00000000;
         slew_q <= 32'h00000000;
         rdata_q <= 8'h00;
         pio_q <= 1'b0;
      end
      else
      begin
         out_q <= out_d;
         oe_q <= oe_d;
         od_q <= od_d;
         slew_q <= slew_d;
         rdata_q <= rdata_d; // [RULE12]
         pio_q <= pio_d;
      end
   end

   assign PIN_OUT = out_q;
   assign PIN_OE = oe_q;
   assign PIN_OPEN_DRAIN = od_q;
   assign PIN_FAST_SLEW = slew_q;
   assign BUS_RDATA = rdata_q;
   assign PERIPH_BUFFER_ENABLE = pio_q;

   // ---------------------------------------------
   // Checks
   // ---------------------------------------------
   sequence s_wr_dir_b;
      BUS_WR && BUS_ADDR == `OFS_DIR_B && BUS_WDATA[0] && !PLA_OE[8];
   endsequence

   // Mode write, then a quiet cycle so only the mode bit acts
   sequence s_wr_mode_a7;
      BUS_WR && BUS_ADDR == `OFS_MODE_A && BUS_WDATA[7];
   endsequence

   sequence s_quiet_a7;
      !BUS_WR && !PLA_CLAIM[7] && !MEM_MAP_MODE[`PERIPH_BIT];
   endsequence

   // Write, one idle cycle, then a read of the same register
   sequence s_wr_drv_a;
      BUS_WR && BUS_ADDR == `OFS_DRV_A;
   endsequence

   sequence s_rd_drv_a;
      !BUS_WR && BUS_RD && BUS_ADDR == `OFS_DRV_A;
   endsequence

   property p_oe_or;
      @(posedge CLK) disable iff (RST)
      !MEM_MAP_MODE[7] |=> PIN_OE[31:8] == $past(dir_all[31:8] | PLA_OE[31:8]);
   endproperty
   a_oe_or: assert property (p_oe_or) // [RULE4]
      else $error("output enable is not direction OR term");

   property p_dir_only;
      @(posedge CLK) disable iff (RST)
      s_wr_dir_b ##1 !PLA_OE[8] |=> PIN_OE[8];
   endproperty
   a_dir_only: assert property (p_dir_only) // [RULE3]
      else $error("direction bit did not make pin output");

   property p_no_term_input;
      @(posedge CLK) disable iff (RST)
      (dir_c[0] == 1'b0 && PLA_OE[16] == 1'b0) |=> !PIN_OE[16];
   endproperty
   a_no_term_input: assert property (p_no_term_input) // [RULE5]
      else $error("pin driven with direction zero and no term");

   property p_addr_out;
      @(posedge CLK) disable iff (RST)
      (mode_b[5] && !PLA_CLAIM[13]) |=> PIN_OUT[13] == $past(LATCHED_ADDR[5]);
   endproperty
   a_addr_out: assert property (p_addr_out) // [RULE10]
      else $error("address bit not driven in address out mode");

   property p_cpu_io;
      @(posedge CLK) disable iff (RST)
      (!PLA_CLAIM[24]) |=> PIN_OUT[24] == $past(DATA_OUT[24]);
   endproperty
   a_cpu_io: assert property (p_cpu_io) // [RULE2]
      else $error("port D pin not in processor I/O mode");

   property p_drive;
      @(posedge CLK) disable iff (RST)
      1'b1 |=> PIN_OPEN_DRAIN[7:0] == ($past(drv_a) & 8'hf0)
         && PIN_FAST_SLEW[7:0] == ($past(drv_a) & 8'h0f);
   endproperty
   a_drive: assert property (p_drive) // [RULE15]
      else $error("drive split wrong on port A");

   property p_portc_od;
      @(posedge CLK) disable iff (RST)
      1'b1 |=> PIN_OPEN_DRAIN[23:16] == $past(drv_c);
   endproperty
   a_portc_od: assert property (p_portc_od) // [RULE8]
      else $error("port C open drain not from drive register");

   property p_readback;
      @(posedge CLK) disable iff (RST)
      s_wr_drv_a ##1 !BUS_WR ##1 s_rd_drv_a
         |=> BUS_RDATA == $past(BUS_WDATA, 3);
   endproperty
   a_readback: assert property (p_readback) // [RULE17]
      else $error("readback differs from written value");

   property p_pio;
      @(posedge CLK) disable iff (RST)
      (MEM_MAP_MODE[7] && !PERIPH_SELECT_A && !PERIPH_SELECT_B)
         |=> PIN_OE[7:0] == 8'h00;
   endproperty
   a_pio: assert property (p_pio) // [RULE14]
      else $error("peripheral buffer not tri-stated");

   property p_addr_mode;
      @(posedge CLK) disable iff (RST)
      s_wr_mode_a7 ##1 s_quiet_a7
         |=> PIN_OUT[7] == $past(LATCHED_ADDR[7]);
   endproperty
   a_addr_mode: assert property (p_addr_mode) // [RULE1]
      else $error("mode bit one did not select address out");

   property p_cpu_io_a;
      @(posedge CLK) disable iff (RST)
      (!mode_a[2] && !PLA_CLAIM[2] && !MEM_MAP_MODE[`PERIPH_BIT])
         |=> PIN_OUT[2] == $past(DATA_OUT[2]);
   endproperty
   a_cpu_io_a: assert property (p_cpu_io_a) // [RULE1]
      else $error("mode bit zero did not select processor data");

   property p_portc_masked;
      @(posedge CLK) disable iff (RST)
      PLA_CLAIM[16] |=> PIN_OUT[16] == $past(DATA_OUT[16]);
   endproperty
   a_portc_masked: assert property (p_portc_masked) // [RULE13]
      else $error("macrocell reached a port C pin without a path");

   property p_portc_claim;
      @(posedge CLK) disable iff (RST)
      PLA_CLAIM[18] |=> PIN_OUT[18] == $past(MACROCELL_GROUP_TWO[2]);
   endproperty
   a_portc_claim: assert property (p_portc_claim) // [RULE13]
      else $error("group two macrocell missing on port C pin 2");

   property p_portb_drive;
      @(posedge CLK) disable iff (RST)
      1'b1 |=> PIN_OPEN_DRAIN[15:8] == ($past(drv_b) & 8'hf0)
         && PIN_FAST_SLEW[15:8] == ($past(drv_b) & 8'h0f);
   endproperty
   a_portb_drive: assert property (p_portb_drive) // [RULE15]
      else $error("drive split wrong on port B");

   property p_portd_drive;
      @(posedge CLK) disable iff (RST)
      1'b1 |=> PIN_FAST_SLEW[31:24] == $past(drv_d)
         && PIN_OPEN_DRAIN[31:24] == 8'h00;
   endproperty
   a_portd_drive: assert property (p_portd_drive) // [RULE9]
      else $error("port D slew not from drive register");

   property p_periph_drive;
      @(posedge CLK) disable iff (RST)
      (MEM_MAP_MODE[`PERIPH_BIT] && (PERIPH_SELECT_A || PERIPH_SELECT_B))
         |=> PIN_OE[7:0] == 8'hff && PERIPH_BUFFER_ENABLE
         && PIN_OUT[7:0] == $past(CPU_DATA_OUT);
   endproperty
   a_periph_drive: assert property (p_periph_drive) // [RULE14]
      else $error("peripheral buffer not driving port A");

   property p_reset_out;
      @(posedge CLK) RST |=> PIN_OUT == 32'h00000000
         && PIN_OE == 32'h00000000 && PIN_OPEN_DRAIN == 32'h00000000
         && PIN_FAST_SLEW == 32'h00000000 && BUS_RDATA == 8'h00
         && !PERIPH_BUFFER_ENABLE;
   endproperty
   a_reset_out: assert property (p_reset_out) // [RULE6]
      else $error("outputs not cleared by reset");
endmodule // port_mode_config

// ### bench/cpu_bus_model.sv
`timescale 1ns/1ns
module cpu_bus_model
   import port_mode_config_pkg::*;
(
   input wire logic clk, // Bus clock
   output logic wr, // Write strobe
   output logic rd, // Read strobe
   output byte_type addr, // Register offset
   output byte_type wdata, // Write data
   input wire logic [7:0] rdata // Read data
);
   initial
   begin
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
   end

   // Idle bus shows inverted values so stale data never looks valid
   task automatic write_reg(input byte_type a, input byte_type d);
      @(posedge clk);
      #1;
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(posedge clk);
      #1;
      wr = 1'b0;
      addr = ~a;
      wdata = ~d;
   endtask

   task automatic read_reg(input byte_type a, output byte_type d);
      @(posedge clk);
      #1;
      rd = 1'b1;
      addr = a;
      @(posedge clk);
      #1;
      d = rdata;
      rd = 1'b0;
      addr = ~a;
   endtask
endmodule // cpu_bus_model

// ### bench/port_mode_config_tb.sv
`timescale 1ns/1ns
`include "port_mode_config_cfg.svh"
module port_mode_config_tb
   import port_mode_config_pkg::*;
;
   logic clk, rst, bus_wr, bus_rd, sel_a, sel_b, periph_en;
   byte_type bus_addr, bus_wdata, bus_rdata, mem_map, cpu_dout, lat_addr;
   byte_type mc_one, mc_two, mc2_to_c, v;
   logic [31:0] data_out, pla_oe, pla_claim, pin_out, pin_oe, pin_od, pin_fast;
   int errors, checks;
   byte_type ofs [10] = '{`OFS_MODE_A, `OFS_MODE_B, `OFS_DIR_A, `OFS_DIR_B,
      `OFS_DIR_C, `OFS_DIR_D, `OFS_DRV_A, `OFS_DRV_B, `OFS_DRV_C, `OFS_DRV_D};
   byte_type msk [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, `DIR_D_MASK,
      8'hff, 8'hff, 8'hff, `DRV_D_MASK};

   port_mode_config dut (.CLK(clk), .RST(rst), .BUS_WR(bus_wr),
      .BUS_RD(bus_rd), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata),
      .BUS_RDATA(bus_rdata), .MEM_MAP_MODE(mem_map),
      .PERIPH_SELECT_A(sel_a), .PERIPH_SELECT_B(sel_b),
      .CPU_DATA_OUT(cpu_dout), .LATCHED_ADDR(lat_addr),
      .DATA_OUT(data_out), .PLA_OE(pla_oe), .PLA_CLAIM(pla_claim),
      .MACROCELL_GROUP_ONE(mc_one), .MACROCELL_GROUP_TWO(mc_two),
      .MC2_TO_C(mc2_to_c), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
      .PIN_OPEN_DRAIN(pin_od), .PIN_FAST_SLEW(pin_fast),
      .PERIPH_BUFFER_ENABLE(periph_en));

   cpu_bus_model cpu (.clk(clk), .wr(bus_wr), .rd(bus_rd), .addr(bus_addr),
      .wdata(bus_wdata), .rdata(bus_rdata));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic test_done();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_chk(input byte_type a, input byte_type e);
      cpu.read_reg(a, v);
      chk(32'(v), 32'(e));
   endtask

   // Registered outputs follow one edge after the cause
   task automatic settle();
      @(posedge clk);
      #1;
   endtask

   task automatic t_reset();
      chk(pin_oe | pin_out | pin_od | pin_fast | 32'(periph_en), 32'h0);
      foreach (ofs[i]) rd_chk(ofs[i], 8'h00);
   endtask

   task automatic t_regs();
      foreach (ofs[i]) cpu.write_reg(ofs[i], 8'ha5 ^ 8'(i));
      foreach (ofs[i]) rd_chk(ofs[i], (8'ha5 ^ 8'(i)) & msk[i]);
      rd_chk(`OFS_DIR_D, 8'h06 & (8'ha5 ^ 8'h05));
      cpu.write_reg(8'h01, 8'hff);
      rd_chk(8'h01, 8'h00);
      foreach (ofs[i]) cpu.write_reg(ofs[i], 8'h00);
   endtask

   task automatic t_drive();
      cpu.write_reg(`OFS_DRV_A, 8'ha5);
      rd_chk(`OFS_DRV_A, 8'ha5);
      cpu.write_reg(`OFS_DRV_C, 8'h3c);
      cpu.write_reg(`OFS_DRV_D, 8'hff);
      settle();
      chk(pin_od, {8'h00, 8'h3c, 8'h00, 8'ha0});
      chk(pin_fast, {8'h06, 8'h00, 8'h00, 8'h05});
   endtask

   task automatic t_dir();
      data_out = 32'h5a5a_5a5a;
      pla_oe = 32'h0000_4000;
      cpu.write_reg(`OFS_DIR_C, 8'h07);
      cpu.write_reg(`OFS_DIR_D, 8'hff);
      settle();
      chk(pin_oe, {8'h06, 8'h07, 8'h40, 8'h00});
      chk(pin_out & pin_oe, data_out & pin_oe);
      pla_oe = 32'h0;
      settle();
      chk(pin_oe, {8'h06, 8'h07, 8'h00, 8'h00});
   endtask

   task automatic t_addr_out();
      lat_addr = 8'h3c;
      data_out = 32'h0000_c3c3;
      cpu.write_reg(`OFS_MODE_A, 8'hf0);
      cpu.write_reg(`OFS_MODE_B, 8'h0f);
      cpu.write_reg(`OFS_DIR_A, 8'hff);
      cpu.write_reg(`OFS_DIR_B, 8'hff);
      settle();
      chk(32'(pin_out[15:0]), 32'h0000_cc33);
   endtask

   task automatic t_periph();
      mem_map = 8'h80;
      cpu_dout = 8'h69;
      settle();
      chk(32'({periph_en, pin_oe[7:0]}), 32'h0);
      sel_a = 1'b1;
      settle();
      chk(32'({periph_en, pin_out[7:0]}), 32'h0000_0169);
      sel_a = 1'b0;
      sel_b = 1'b1;
      settle();
      chk(32'(periph_en), 32'h1);
      sel_b = 1'b0;
      mem_map = 8'h00;
   endtask

   task automatic t_portc();
      data_out = 32'h0;
      pla_claim = 32'h00ff_0000;
      mc2_to_c = 8'hff;
      mc_two = 8'hff;
      cpu.write_reg(`OFS_DIR_C, 8'hff);
      settle();
      chk(32'(pin_out[23:16]), 32'h0000_009c);
   endtask

   initial
   begin
      errors = 0;
      checks = 0;
      rst = 1'b1;
      {sel_a, sel_b, mem_map, cpu_dout, lat_addr} = '0;
      {mc_one, mc_two, mc2_to_c, data_out, pla_oe, pla_claim} = '0;
      repeat (10) @(posedge clk);
      #1;
      rst = 1'b0;
      t_reset();
      t_regs();
      t_drive();
      t_dir();
      t_addr_out();
      t_periph();
      t_portc();
      test_done();
   end

   initial
   begin
      #2000000;
      errors++;
      test_done();
   end
endmodule // port_mode_config_tb
